// [logic/watchdog_timer_24bit.sv]
// 24-bit watchdog: rc tick counter, unlock sequencer, apb registers
//
// Behaviour
// - 24-bit down-counter reloaded from three 8-bit software registers.
// - reload value is upper, high, low bytes, upper most significant.
// - counter decrements once per rc oscillator period, nominally 10 kHz.
// - only off and on; once on it counts and software cannot stop it.
// - turns on at first refresh, or at reset when always-on option set.
// - counter loads the current reload value when first enabled.
// - each refresh reloads the counter, then counting resumes.
// - refresh ignored once counter is at 000002H or lower.
// - time-out at count 000000H gives an interrupt or a system reset.
// - response-select option bit picks interrupt or reset response.
// - interrupt response outside stop: interrupt request and status bit.
// - after interrupt time-out counter goes to FFFFFH and keeps counting.
// - reading reset status clears the time-out flag.
// - interrupt response in stop: recovery, interrupt, status and stop bits.
// - reset response outside stop: system reset and status bit.
// - reset response in stop: recovery instead of reset, both bits set.
// - reload bytes writable only after 55H, AAH then upper, high, low.
// - any other write mid-sequence relocks until restarted.
// - unlock writes store nothing; they only advance the sequencer.
// - reads of reload addresses return the current count.
// - control address writes go to unlock logic, reads give status.
`timescale 1ns/1ps

module watchdog_timer_24bit
  import wdt_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire logic rc_osc_i,
  input wire logic refresh_instr_i,
  input wire logic always_on_option_i,
  input wire logic timeout_response_select_i,
  input wire logic stop_mode_i,
  input wire apb_req_s apb_i,
  output apb_rsp_s apb_o,
  output logic irq_o,
  output logic sys_reset_o,
  output logic stop_recovery_o,
  output logic wdt_on_o
);

  logic [1:0] rst_sync;
  logic rst_n;
  wdt_state_s st;
  wdt_state_s next_st;
  logic osc_tick;
  logic [CNT_W-1:0] reload;
  logic acc;
  logic xfer;
  logic refresh_ok;
  logic timeout;
  sel_e sel;
  logic [7:0] wbyte;

  function automatic sel_e decode(input logic [ADDR_W-1:0] a);
    if (a[1:0] != 2'b00) begin
      return SEL_NONE;
    end else if (a[ADDR_W-1:2] == IDX_CTRL) begin
      return SEL_CTRL;
    end else if (a[ADDR_W-1:2] == IDX_UPPER) begin
      return SEL_UPPER;
    end else if (a[ADDR_W-1:2] == IDX_HIGH) begin
      return SEL_HIGH;
    end else if (a[ADDR_W-1:2] == IDX_LOW) begin
      return SEL_LOW;
    end else begin
      return SEL_NONE;
    end
  endfunction : decode

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  assign reload = {st.rel_u, st.rel_h, st.rel_l};
  // the oscillator is far slower than ref_clk, so an edge detect suffices
  assign osc_tick = st.osc_sync[1] & ~st.osc_prev;
  assign acc = apb_i.psel & apb_i.penable;
  assign xfer = acc & st.rsp.pready;
  assign sel = decode(apb_i.paddr);
  assign wbyte = apb_i.pwdata[7:0];
  assign refresh_ok = st.started & st.on & refresh_instr_i &
                      (st.count > REFRESH_FLOOR);
  assign timeout = st.started & st.on & ~refresh_ok & osc_tick &
                   (st.count == CNT_ZERO);

  always_comb begin
    next_st = st;
    // first flop feeds only the second
    next_st.osc_sync = {st.osc_sync[0], rc_osc_i};
    next_st.osc_prev = st.osc_sync[1];
    next_st.irq = 1'b0;
    next_st.sys_reset = 1'b0;
    next_st.stop_rec = 1'b0;
    next_st.rsp.pready = acc & ~st.rsp.pready;

    if (!st.started) begin
      // option bits are caught once, the cycle after reset release
      next_st.started = 1'b1;
      next_st.resp_sel = timeout_response_select_i;
      if (always_on_option_i) begin
        next_st.on = 1'b1;
        next_st.count = reload;
      end
    end else if (refresh_instr_i && !st.on) begin
      next_st.on = 1'b1;
      next_st.count = reload;
    end else if (refresh_ok) begin
      next_st.count = reload;
    end else if (st.on && osc_tick) begin
      if (st.count == CNT_ZERO) begin
        if (st.resp_sel == RESP_RESET) begin
          next_st.count = reload;
        end else begin
          next_st.count = CNT_AFTER_IRQ;
        end
      end else begin
        next_st.count = st.count - CNT_STEP;
      end
    end

    // bus read data is prepared the cycle before pready
    if (acc && !st.rsp.pready) begin
      next_st.rsp.pslverr = 1'b0;
      next_st.rsp.prdata = 32'h0000_0000;
      if (sel == SEL_CTRL) begin
        next_st.rsp.prdata[STAT_WDT_BIT] = st.flag_wdt;
        next_st.rsp.prdata[STAT_STOP_BIT] = st.flag_stop;
      end else if (sel == SEL_UPPER) begin
        next_st.rsp.prdata[7:0] = st.count[23:16];
      end else if (sel == SEL_HIGH) begin
        next_st.rsp.prdata[7:0] = st.count[15:8];
      end else if (sel == SEL_LOW) begin
        next_st.rsp.prdata[7:0] = st.count[7:0];
      end else begin
        next_st.rsp.pslverr = 1'b1;
      end
    end

    if (xfer && !apb_i.pwrite && sel == SEL_CTRL) begin
      next_st.flag_wdt = 1'b0;
      next_st.flag_stop = 1'b0;
    end

    if (xfer && apb_i.pwrite) begin
      case (sel)
        SEL_CTRL: begin
          // unlock codes are never stored anywhere
          if (st.lock == GOT_FIRST && wbyte == UNLOCK_SECOND) begin
            next_st.lock = WANT_UPPER;
          end else if (wbyte == UNLOCK_FIRST) begin
            next_st.lock = GOT_FIRST;
          end else begin
            next_st.lock = LOCKED;
          end
        end
        SEL_UPPER: begin
          if (st.lock == WANT_UPPER) begin
            next_st.rel_u = wbyte;
            next_st.lock = WANT_HIGH;
          end else begin
            next_st.lock = LOCKED;
          end
        end
        SEL_HIGH: begin
          if (st.lock == WANT_HIGH) begin
            next_st.rel_h = wbyte;
            next_st.lock = WANT_LOW;
          end else begin
            next_st.lock = LOCKED;
          end
        end
        SEL_LOW: begin
          if (st.lock == WANT_LOW) begin
            next_st.rel_l = wbyte;
          end
          next_st.lock = LOCKED;
        end
        default: begin
          next_st.lock = LOCKED;
        end
      endcase
    end

    // time-out flags set after the read clear, so a set wins
    if (timeout) begin
      next_st.flag_wdt = 1'b1;
      if (stop_mode_i) begin
        next_st.stop_rec = 1'b1;
        next_st.flag_stop = 1'b1;
        next_st.irq = (st.resp_sel != RESP_RESET);
      end else if (st.resp_sel == RESP_RESET) begin
        next_st.sys_reset = 1'b1;
      end else begin
        next_st.irq = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RST;
    end else if (clk_en_i) begin
      st <= next_st;
    end
  end

  assign apb_o = st.rsp;
  assign irq_o = st.irq;
  assign sys_reset_o = st.sys_reset;
  assign stop_recovery_o = st.stop_rec;
  assign wdt_on_o = st.on;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n);

  a_refresh_reload: assert property (
    clk_en_i && refresh_ok |=> st.count == $past(reload))
    else $error("refresh did not reload the counter");

  a_refresh_floor: assert property (
    clk_en_i && st.on && refresh_instr_i && st.count <= REFRESH_FLOOR &&
    !osc_tick |=> st.count == $past(st.count))
    else $error("refresh accepted at or below floor");

  a_tick_decrement: assert property (
    clk_en_i && st.on && osc_tick && !refresh_ok && st.count != CNT_ZERO
    |=> st.count == $past(st.count) - CNT_STEP)
    else $error("counter did not step down on tick");

  a_irq_max_count: assert property (
    clk_en_i && timeout && st.resp_sel != RESP_RESET
    |=> st.count == CNT_AFTER_IRQ && irq_o ##1 !irq_o)
    else $error("interrupt time-out wrong count or pulse");

  a_reset_response: assert property (
    clk_en_i && timeout && st.resp_sel == RESP_RESET && !stop_mode_i
    |=> sys_reset_o && !irq_o && !stop_recovery_o && st.flag_wdt)
    else $error("reset response missing");

  a_stop_recovery: assert property (
    clk_en_i && timeout && stop_mode_i
    |=> stop_recovery_o && !sys_reset_o && st.flag_stop && st.flag_wdt)
    else $error("stop recovery missing");

  a_status_clear: assert property (
    clk_en_i && xfer && !apb_i.pwrite && sel == SEL_CTRL && !timeout
    |=> !st.flag_wdt && !st.flag_stop)
    else $error("status read did not clear flags");

  a_reload_locked: assert property (
    st.rel_u != $past(st.rel_u) |-> $past(st.lock) == WANT_UPPER)
    else $error("upper reload written while locked");

  a_ctrl_no_store: assert property (
    xfer && apb_i.pwrite && sel == SEL_CTRL
    |=> $stable(st.rel_u) && $stable(st.rel_h) && $stable(st.rel_l))
    else $error("unlock write changed reload bytes");

  a_always_on: assert property (
    $rose(st.started) && $past(always_on_option_i) && $past(clk_en_i)
    |-> st.on && st.count == reload)
    else $error("always-on did not start the counter");

  a_never_off: assert property (
    st.on |=> st.on)
    else $error("watchdog turned off");

  a_pready_pulse: assert property (
    apb_o.pready |=> !apb_o.pready)
    else $error("pready held longer than one cycle");

  a_first_enable: assert property (
    clk_en_i && st.started && refresh_instr_i && !st.on
    |=> st.on && st.count == $past(reload))
    else $error("first enable did not load the reload value");

  a_irq_normal: assert property (
    clk_en_i && timeout && st.resp_sel != RESP_RESET && !stop_mode_i
    |=> irq_o && !sys_reset_o && !stop_recovery_o && st.flag_wdt)
    else $error("interrupt response missing");

  a_irq_in_stop: assert property (
    clk_en_i && timeout && st.resp_sel != RESP_RESET && stop_mode_i
    |=> irq_o && stop_recovery_o && st.flag_wdt && st.flag_stop)
    else $error("interrupt response in stop missing");

  a_event_cause: assert property (
    $rose(irq_o) || $rose(sys_reset_o) || $rose(stop_recovery_o)
    |-> $past(timeout))
    else $error("response pulse without a time-out");

  a_reset_reload: assert property (
    clk_en_i && timeout && st.resp_sel == RESP_RESET
    |=> st.count == $past(reload))
    else $error("reset response did not reload the counter");

  a_resp_fixed: assert property (
    st.started |=> $stable(st.resp_sel))
    else $error("response select changed after start");

  a_off_idle: assert property (
    clk_en_i && st.started && !st.on && !refresh_instr_i
    |=> !st.on && $stable(st.count))
    else $error("watchdog started without a refresh");

  a_count_hold: assert property (
    clk_en_i && st.on && !osc_tick && !refresh_instr_i
    |=> $stable(st.count))
    else $error("counter moved without a tick");

  a_upper_write: assert property (
    clk_en_i && xfer && apb_i.pwrite && sel == SEL_UPPER &&
    st.lock == WANT_UPPER |=> st.rel_u == $past(wbyte) &&
    st.lock == WANT_HIGH)
    else $error("unlocked upper write not taken");

  a_high_write: assert property (
    clk_en_i && xfer && apb_i.pwrite && sel == SEL_HIGH &&
    st.lock == WANT_HIGH |=> st.rel_h == $past(wbyte) &&
    st.lock == WANT_LOW)
    else $error("unlocked high write not taken");

  a_low_write: assert property (
    clk_en_i && xfer && apb_i.pwrite && sel == SEL_LOW &&
    st.lock == WANT_LOW |=> st.rel_l == $past(wbyte) &&
    st.lock == LOCKED)
    else $error("unlocked low write not taken");

  a_high_locked: assert property (
    st.rel_h != $past(st.rel_h) |-> $past(st.lock) == WANT_HIGH)
    else $error("high reload written while locked");

  a_relock_other: assert property (
    clk_en_i && xfer && apb_i.pwrite && sel == SEL_NONE
    |=> st.lock == LOCKED)
    else $error("unmapped write did not relock");

  a_second_code: assert property (
    clk_en_i && xfer && apb_i.pwrite && sel == SEL_CTRL &&
    st.lock == GOT_FIRST && wbyte == UNLOCK_SECOND
    |=> st.lock == WANT_UPPER)
    else $error("second unlock code not accepted");

  a_read_count: assert property (
    clk_en_i && acc && !apb_o.pready && sel == SEL_LOW
    |=> apb_o.prdata == {24'h000000, $past(st.count[7:0])})
    else $error("low byte read did not return the count");

  a_status_read: assert property (
    clk_en_i && acc && !apb_o.pready && sel == SEL_CTRL
    |=> apb_o.prdata[STAT_WDT_BIT] == $past(st.flag_wdt) &&
    apb_o.prdata[STAT_STOP_BIT] == $past(st.flag_stop))
    else $error("status read returned wrong flags");

  a_bad_addr: assert property (
    clk_en_i && acc && !apb_o.pready && sel == SEL_NONE
    |=> apb_o.pslverr)
    else $error("unmapped access without slave error");

  a_pready_wait: assert property (
    clk_en_i && acc && !apb_o.pready |=> apb_o.pready)
    else $error("pready missing after one wait state");

  c_irq_timeout: cover property (timeout && st.resp_sel != RESP_RESET);
  c_reset_timeout: cover property (timeout && st.resp_sel == RESP_RESET);
  c_unlock_done: cover property (
    xfer && apb_i.pwrite && sel == SEL_LOW && st.lock == WANT_LOW);
  c_refresh_ok: cover property (refresh_ok);
  c_stop_timeout: cover property (timeout && stop_mode_i);

endmodule : watchdog_timer_24bit

// [logic/wdt_pkg.sv]
// constants, types and state layout for the 24-bit watchdog
package wdt_pkg;

  localparam int ADDR_W = 14;
  localparam int CNT_W = 24;

  // offsets are register indices; the byte address is index times four
  localparam logic [11:0] IDX_CTRL = 12'hFF0;
  localparam logic [11:0] IDX_UPPER = 12'hFF1;
  localparam logic [11:0] IDX_HIGH = 12'hFF2;
  localparam logic [11:0] IDX_LOW = 12'hFF3;

  localparam logic [7:0] UNLOCK_FIRST = 8'h55;
  localparam logic [7:0] UNLOCK_SECOND = 8'hAA;

  localparam logic [7:0] UPPER_RST = 8'h00;
  localparam logic [7:0] HIGH_RST = 8'h04;
  localparam logic [7:0] LOW_RST = 8'h00;

  localparam logic [23:0] CNT_AFTER_IRQ = 24'h0FFFFF;
  localparam logic [23:0] REFRESH_FLOOR = 24'h000002;
  localparam logic [23:0] CNT_ZERO = 24'h000000;
  localparam logic [23:0] CNT_STEP = 24'h000001;

  localparam int STAT_WDT_BIT = 5;
  localparam int STAT_STOP_BIT = 4;

  // response select level meaning system reset; the other level is interrupt
  localparam logic RESP_RESET = 1'b0;

  typedef enum logic [2:0] {
    LOCKED,
    GOT_FIRST,
    WANT_UPPER,
    WANT_HIGH,
    WANT_LOW
  } lock_e;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_UPPER,
    SEL_HIGH,
    SEL_LOW,
    SEL_NONE
  } sel_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [1:0] osc_sync;
    logic osc_prev;
    logic started;
    logic resp_sel;
    logic on;
    logic [CNT_W-1:0] count;
    logic [7:0] rel_u;
    logic [7:0] rel_h;
    logic [7:0] rel_l;
    lock_e lock;
    logic flag_wdt;
    logic flag_stop;
    apb_rsp_s rsp;
    logic irq;
    logic sys_reset;
    logic stop_rec;
  } wdt_state_s;

  localparam wdt_state_s ST_RST = '{
    osc_sync: 2'b00,
    osc_prev: 1'b0,
    started: 1'b0,
    resp_sel: RESP_RESET,
    on: 1'b0,
    count: CNT_ZERO,
    rel_u: UPPER_RST,
    rel_h: HIGH_RST,
    rel_l: LOW_RST,
    lock: LOCKED,
    flag_wdt: 1'b0,
    flag_stop: 1'b0,
    rsp: '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0},
    irq: 1'b0,
    sys_reset: 1'b0,
    stop_rec: 1'b0
  };

endpackage : wdt_pkg

// [test/cpu_side_model.sv]
// cpu-side partner: issues refresh pulses and counts the responses
`timescale 1ns/1ps

module cpu_side_model (
  input wire logic clk_i,
  input wire logic refresh_req_i,
  input wire logic irq_i,
  input wire logic sys_reset_i,
  input wire logic stop_rec_i,
  output logic refresh_o,
  output int n_irq_o,
  output int n_rst_o,
  output int n_rec_o
);
  // one-cycle refresh per request, registered on clk_i
  always @(posedge clk_i) begin
    refresh_o <= refresh_req_i;
    n_irq_o <= n_irq_o + int'(irq_i === 1'b1);
    n_rst_o <= n_rst_o + int'(sys_reset_i === 1'b1);
    n_rec_o <= n_rec_o + int'(stop_rec_i === 1'b1);
  end
endmodule : cpu_side_model

// [test/tb_watchdog_timer_24bit.sv]
// self-checking bench for the 24-bit watchdog
`timescale 1ns/1ps

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
  n_fail++; $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module tb_watchdog_timer_24bit;
  import wdt_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, rc_osc = 1'b0, refresh_req = 1'b0;
  logic refresh, ao = 1'b0, rsel = 1'b0, stop = 1'b0;
  logic irq, sys_rst, stop_rec, wdt_on, err;
  logic [31:0] rd;
  apb_req_s req = '0;
  apb_rsp_s rsp;
  int n_irq, n_rst, n_rec, n_fail = 0, n_compared = 0, osc_cnt = 0;
  int ml = 0, mr = 'h400, e_irq = 0, e_rst = 0, e_rec = 0, rnd;

  watchdog_timer_24bit watchdog_timer_24bit_inst (.ref_clk_i(ref_clk),
    .resetn_i(resetn), .clk_en_i(1'b1), .rc_osc_i(rc_osc),
    .refresh_instr_i(refresh), .always_on_option_i(ao),
    .timeout_response_select_i(rsel), .stop_mode_i(stop), .apb_i(req),
    .apb_o(rsp), .irq_o(irq), .sys_reset_o(sys_rst),
    .stop_recovery_o(stop_rec), .wdt_on_o(wdt_on));
  cpu_side_model cpu_side_model_inst (.clk_i(ref_clk),
    .refresh_req_i(refresh_req), .irq_i(irq), .sys_reset_i(sys_rst),
    .stop_rec_i(stop_rec), .refresh_o(refresh), .n_irq_o(n_irq),
    .n_rst_o(n_rst), .n_rec_o(n_rec));

  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // rc oscillator far faster than 10 kHz so time-outs fit in a short run
  always @(posedge ref_clk) begin
    osc_cnt <= (osc_cnt == 4) ? 0 : osc_cnt + 1;
    if (osc_cnt == 4) rc_osc <= ~rc_osc;
  end

  task automatic print_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {a, 2'b00},
      pwdata: {24'h0, d}};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do @(posedge ref_clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // lock sequencer and reload value as software should see them
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    bit first;
    apb(1'b1, a, d);
    first = (a == IDX_CTRL) && (d == UNLOCK_FIRST);
    if (ml == 1 && a == IDX_CTRL && d == UNLOCK_SECOND) ml = 2;
    else if (ml == 2 && a == IDX_UPPER) begin
      mr = (mr & 'hFFFF) | (int'(d) << 16);
      ml = 3;
    end else if (ml == 3 && a == IDX_HIGH) begin
      mr = (mr & 'hFF00FF) | (int'(d) << 8);
      ml = 4;
    end else if (ml == 4 && a == IDX_LOW) begin
      mr = (mr & 'hFFFF00) | int'(d);
      ml = 0;
    end else ml = first ? 1 : 0;
  endtask : wr

  task automatic rdc(input logic [11:0] a, input int e, input string nm);
    apb(1'b0, a, 8'h00);
    `CHK(nm, 32'(e), rd)
  endtask : rdc

  task automatic prog(input int v);
    wr(IDX_CTRL, UNLOCK_FIRST);
    wr(IDX_CTRL, UNLOCK_SECOND);
    wr(IDX_UPPER, 8'(v >> 16));
    wr(IDX_HIGH, 8'(v >> 8));
    wr(IDX_LOW, 8'(v));
  endtask : prog

  task automatic refr;
    @(posedge ref_clk) refresh_req <= 1'b1;
    @(posedge ref_clk) refresh_req <= 1'b0;
  endtask : refr

  // bounded wait for any response pulse
  task automatic wait_ev;
    int b;
    b = n_irq + n_rst + n_rec;
    repeat (3000) begin
      @(posedge ref_clk);
      if (n_irq + n_rst + n_rec != b) break;
    end
    repeat (3) @(posedge ref_clk);
  endtask : wait_ev

  task automatic rst(input logic ao_v, input logic rsel_v);
    resetn <= 1'b0;
    ao <= ao_v;
    rsel <= rsel_v;
    stop <= 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (6) @(posedge ref_clk);
    ml = 0;
    mr = 'h400;
  endtask : rst

  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end

  initial begin
    rnd = $urandom(32'h75a1c986);
    rst(1'b0, 1'b0);
    `CHK("on_off", 1'b0, wdt_on)
    rdc(IDX_CTRL, 0, "status");
    apb(1'b0, 12'hFF4, 8'h00);
    `CHK("slverr", 1'b1, err)
    wr(IDX_CTRL, UNLOCK_FIRST);
    wr(IDX_CTRL, UNLOCK_SECOND);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_UPPER, 8'h02);
    rdc(IDX_CTRL, 0, "status");
    refr();
    repeat (2) @(posedge ref_clk);
    `CHK("on", 1'b1, wdt_on)
    rdc(IDX_UPPER, mr >> 16, "relock");
    prog('h018080 | ($urandom % 128));
    refr();
    rdc(IDX_UPPER, mr >> 16, "upper");
    rdc(IDX_HIGH, (mr >> 8) & 255, "high");
    prog(4 + ($urandom % 12));
    refr();
    repeat (60) begin
      apb(1'b0, IDX_LOW, 8'h00);
      if (rd == 32'h2) break;
    end
    `CHK("poll", 32'h2, rd)
    refr();
    apb(1'b0, IDX_LOW, 8'h00);
    `CHK("floor", 1'b1, rd <= 32'h2)
    wait_ev();
    e_rst++;
    `CHK("rst", e_rst, n_rst)
    rdc(IDX_CTRL, 'h20, "st_rst");
    rdc(IDX_CTRL, 0, "st_clr");
    stop <= 1'b1;
    wait_ev();
    e_rec++;
    `CHK("rec", e_rec, n_rec)
    `CHK("no_rst", e_rst, n_rst)
    rdc(IDX_CTRL, 'h30, "st_stop");
    rst(1'b1, 1'b1);
    `CHK("ao_on", 1'b1, wdt_on)
    prog(4 + ($urandom % 12));
    refr();
    wait_ev();
    e_irq++;
    `CHK("irq", e_irq, n_irq)
    rdc(IDX_UPPER, 'h0F, "max");
    rdc(IDX_CTRL, 'h20, "st_irq");
    rdc(IDX_CTRL, 0, "st_clr2");
    stop <= 1'b1;
    refr();
    wait_ev();
    e_irq++;
    e_rec++;
    `CHK("irq_stop", e_irq, n_irq)
    `CHK("rec_stop", e_rec, n_rec)
    rdc(IDX_CTRL, 'h30, "st_istop");
    print_verdict();
  end
endmodule : tb_watchdog_timer_24bit
